// [lcd_seg_pkg.sv]
// Shared constants and types of the segment driver.
// Assumes nothing of its surroundings; compile before the modules.
package lcd_seg_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int SEG_COUNT = 80;
   localparam int CHAIN_LEN = 160;

   // ************************************************************
   // Three-level drive codes of the backplane outputs
   // ************************************************************
   localparam logic [1:0] LEVEL_LOW  = 2'h0;
   localparam logic [1:0] LEVEL_MID  = 2'h1;
   localparam logic [1:0] LEVEL_HIGH = 2'h2;

   // ************************************************************
   // Oscillator divider ratios, counter start and step
   // ************************************************************
   localparam logic [3:0] DIV_STATIC  = 4'h8;
   localparam logic [3:0] DIV_DYNAMIC = 4'h4;
   localparam logic [3:0] DIV_START   = 4'h0;
   localparam logic [3:0] DIV_STEP    = 4'h1;

   // Cycles after an own sync pulse in which the line is not obeyed
   localparam int SYNC_GUARD = 4;

   // ************************************************************
   // Backplane sequencing states
   // ************************************************************
   typedef enum logic [2:0] {
      PHASE_STATIC = 3'b001,
      SELECT_A     = 3'b010,
      SELECT_B     = 3'b100
   } phase_type;

endpackage : lcd_seg_pkg

// [bit_sync.sv]
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  logic             clk,
   input  logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   // ************************************************************
   // Stages
   // ************************************************************
   logic [WIDTH-1:0] meta_reg;

   // No reset: the stages flush within two edges
   always_ff @(posedge clk) begin
      meta_reg <= d;
      q        <= meta_reg;
   end

endmodule : bit_sync

// [lcd_seg_driver.sv]
// Static / half-duty LCD segment driver: serial chain, latch, drivers.
// Assumes clk is free running; osc_clk is the oscillator clock and runs
// whenever the display is to be driven; all pins are asynchronous.
//
// Operation
// - Each shift clock rise moves the data bit into the 160-stage chain.
// - A one in a display bit lights the segment, a zero darkens it.
// - The half-chain output always shows chain stage 80.
// - The full-chain output always shows chain stage 160.
// - Load high passes the chain to the drivers; load low holds it.
// - Source select high takes the common clock input as common signal.
// - Dynamic mode shares the open-drain sync line to align backplanes.
// - Static mode drives both backplanes two-level, in phase with common.
// - Dynamic backplanes take turns; selected follows common, other mid.
// - Dynamic segment N shows bit N under A, bit 80+N under B.
// - Static segment N shows bit N; bits from 81 are unused.
// - A lit segment is driven inverse to common, a dark one in phase.
// - All-on test high lights every segment; low restores the display.
// - Force-off high darkens every segment; low restores the display.
// - The all-on test overrides force-off.
// - Mode select high chooses dynamic, low chooses static.
// - The oscillator is divided by 8 in static and 4 in dynamic mode.
`timescale 1ns/1ps
module lcd_seg_driver #(
   parameter int SEG_N   = lcd_seg_pkg::SEG_COUNT,
   parameter int CHAIN_N = lcd_seg_pkg::CHAIN_LEN
) (
   input  logic             clk,
   input  logic             sys_rst,
   input  logic             shift_clk,
   input  logic             serial_data_in,
   input  logic             load_in,
   input  logic             display_mode_dynamic,
   input  logic             common_source_select,
   input  logic             common_clock_in,
   input  logic             osc_clk,
   input  logic             all_on_test,
   input  logic             force_off,
   input  logic             sync_in,
   output logic             sync_out,
   output logic             sync_oe_n,
   output logic             half_chain_out,
   output logic             full_chain_out,
   output logic             common_phase_out,
   output logic [1:0]       backplane_a,
   output logic [1:0]       backplane_b,
   output logic [SEG_N-1:0] segment_outputs
);

   // ************************************************************
   // Serial side, clk domain
   // ************************************************************
   logic [2:0]         host_s;
   logic               shift_d_reg;
   logic               shift_rise;
   logic [CHAIN_N-1:0] chain_reg;
   logic [CHAIN_N-1:0] chain_next;
   logic [CHAIN_N-1:0] latch_reg;
   logic [CHAIN_N-1:0] xfer_reg;
   logic               req_reg;
   logic               ack_s;

   bit_sync #(.WIDTH(3)) host_sync (
      .clk (clk),
      .d   ({shift_clk, serial_data_in, load_in}),
      .q   (host_s)
   );

   assign shift_rise = host_s[2] & ~shift_d_reg;
   assign chain_next = shift_rise ?
                       {chain_reg[CHAIN_N-2:0], host_s[1]} : chain_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_d_reg <= 1'b0;
      end else begin
         shift_d_reg <= host_s[2];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chain_reg      <= '0;
         half_chain_out <= 1'b0;
         full_chain_out <= 1'b0;
      end else begin
         chain_reg      <= chain_next;
         half_chain_out <= chain_next[SEG_N-1];
         full_chain_out <= chain_next[CHAIN_N-1];
      end
   end

   // Latch follows the chain only while load is high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_reg <= '0;
      end else if (host_s[0]) begin
         latch_reg <= chain_reg;
      end
   end

   // Snapshot held still until the oscillator side acknowledges it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xfer_reg <= '0;
         req_reg  <= 1'b0;
      end else if (ack_s == req_reg) begin
         xfer_reg <= latch_reg;
         req_reg  <= ~req_reg;
      end
   end

   // ************************************************************
   // Display side, oscillator domain
   // ************************************************************
   logic               osc_rst;
   logic [6:0]         osc_s;
   logic               req_s;
   logic               ack_reg;
   logic [CHAIN_N-1:0] disp_reg;
   logic               dyn;
   logic               ext_sel;
   logic               ext_com;
   logic               all_on;
   logic               blank;
   logic               sync_line;
   logic               sync_d_reg;
   logic [3:0]         div_reg;
   logic [3:0]         div_next;
   logic [3:0]         div_len;
   logic               com_next;
   logic               realign;
   logic               pulse;
   logic [lcd_seg_pkg::SYNC_GUARD-1:0] drv_hist_reg;
   logic [SEG_N-1:0]   lit;
   lcd_seg_pkg::phase_type state_reg;
   lcd_seg_pkg::phase_type state_next;

   bit_sync #(.WIDTH(1)) rst_sync (
      .clk (osc_clk),
      .d   (sys_rst),
      .q   (osc_rst)
   );

   bit_sync #(.WIDTH(7)) pin_sync (
      .clk (osc_clk),
      .d   ({display_mode_dynamic, common_source_select, common_clock_in,
             all_on_test, force_off, sync_in, req_reg}),
      .q   (osc_s)
   );

   assign dyn       = osc_s[6];
   assign ext_sel   = osc_s[5];
   assign ext_com   = osc_s[4];
   assign all_on    = osc_s[3];
   assign blank     = osc_s[2];
   assign sync_line = osc_s[1];
   assign req_s     = osc_s[0];

   bit_sync #(.WIDTH(1)) ack_sync (
      .clk (clk),
      .d   (ack_reg),
      .q   (ack_s)
   );

   always_ff @(posedge osc_clk) begin
      if (osc_rst) begin
         disp_reg <= '0;
         ack_reg  <= 1'b0;
      end else if (req_s != ack_reg) begin
         disp_reg <= xfer_reg;
         ack_reg  <= ~ack_reg;
      end
   end

   // Level code of one backplane from its select and the common phase
   function automatic logic [1:0] level_of(input logic sel,
                                           input logic com);
      if (!sel) begin
         level_of = lcd_seg_pkg::LEVEL_MID;
      end else if (com) begin
         level_of = lcd_seg_pkg::LEVEL_HIGH;
      end else begin
         level_of = lcd_seg_pkg::LEVEL_LOW;
      end
   endfunction : level_of

   // Realign on a sync fall made by another chip; own pulses are ignored
   assign realign = dyn & sync_d_reg & ~sync_line & ~(|drv_hist_reg);

   always_comb begin
      div_len  = dyn ? lcd_seg_pkg::DIV_DYNAMIC : lcd_seg_pkg::DIV_STATIC;
      div_next = div_reg + lcd_seg_pkg::DIV_STEP;
      if (realign || div_next >= div_len) begin
         div_next = lcd_seg_pkg::DIV_START;
      end
      if (ext_sel) begin
         com_next = ext_com;
      end else begin
         com_next = div_next < (div_len >> 1);
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         lcd_seg_pkg::PHASE_STATIC: begin
            if (dyn) begin
               state_next = lcd_seg_pkg::SELECT_A;
            end
         end
         lcd_seg_pkg::SELECT_A: begin
            if (com_next && !common_phase_out) begin
               state_next = lcd_seg_pkg::SELECT_B;
            end
         end
         lcd_seg_pkg::SELECT_B: begin
            if (com_next && !common_phase_out) begin
               state_next = lcd_seg_pkg::SELECT_A;
            end
         end
         default: state_next = lcd_seg_pkg::PHASE_STATIC;
      endcase
      if (!dyn) begin
         state_next = lcd_seg_pkg::PHASE_STATIC;
      end else if (realign) begin
         state_next = lcd_seg_pkg::SELECT_A;
      end
   end

   assign pulse = dyn && !realign &&
                  state_next == lcd_seg_pkg::SELECT_A &&
                  state_reg != lcd_seg_pkg::SELECT_A;

   always_ff @(posedge osc_clk) begin
      if (osc_rst) begin
         state_reg        <= lcd_seg_pkg::PHASE_STATIC;
         div_reg          <= lcd_seg_pkg::DIV_START;
         common_phase_out <= 1'b0;
      end else begin
         state_reg        <= state_next;
         div_reg          <= div_next;
         common_phase_out <= com_next;
      end
   end

   // Static mode never pulls the line: it is grounded there
   always_ff @(posedge osc_clk) begin
      if (osc_rst) begin
         sync_out     <= 1'b0;
         sync_oe_n    <= 1'b1;
         sync_d_reg   <= 1'b1;
         drv_hist_reg <= '0;
      end else begin
         sync_out     <= 1'b0;
         sync_oe_n    <= ~pulse;
         sync_d_reg   <= sync_line;
         drv_hist_reg <= {drv_hist_reg[lcd_seg_pkg::SYNC_GUARD-2:0],
                          pulse};
      end
   end

   always_ff @(posedge osc_clk) begin
      if (osc_rst) begin
         backplane_a <= lcd_seg_pkg::LEVEL_LOW;
         backplane_b <= lcd_seg_pkg::LEVEL_LOW;
      end else begin
         backplane_a <= level_of(state_next != lcd_seg_pkg::SELECT_B,
                                 com_next);
         backplane_b <= level_of(state_next != lcd_seg_pkg::SELECT_A,
                                 com_next);
      end
   end

   always_comb begin
      if (state_next == lcd_seg_pkg::SELECT_B) begin
         lit = disp_reg[CHAIN_N-1:SEG_N];
      end else begin
         lit = disp_reg[SEG_N-1:0];
      end
      if (all_on) begin
         lit = '1;
      end else if (blank) begin
         lit = '0;
      end
   end

   always_ff @(posedge osc_clk) begin
      if (osc_rst) begin
         segment_outputs <= '0;
      end else begin
         segment_outputs <= lit ^ {SEG_N{com_next}};
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   shift_in_a: assert property (@(posedge clk) disable iff (sys_rst)
      shift_rise |=> chain_reg[0] == $past(host_s[1]) &&
                     chain_reg[1] == $past(chain_reg[0]))
      else $error("chain did not shift on shift clock rise");

   half_tap_a: assert property (@(posedge clk) disable iff (sys_rst)
      shift_rise |=> half_chain_out == $past(chain_reg[SEG_N-2]))
      else $error("half-chain output differs from stage 80");

   full_tap_a: assert property (@(posedge clk) disable iff (sys_rst)
      shift_rise |=> full_chain_out == $past(chain_reg[CHAIN_N-2]))
      else $error("full-chain output differs from last stage");

   latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !host_s[0] ##1 !host_s[0] |=> $stable(latch_reg))
      else $error("latch changed while load low");

   latch_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
      host_s[0] |=> latch_reg == $past(chain_reg))
      else $error("latch did not follow chain while load high");

   ext_common_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst) ext_sel |=> common_phase_out == $past(ext_com))
      else $error("external common not passed to phase output");

   static_bp_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst) !dyn ##1 !dyn |-> backplane_a == backplane_b &&
         backplane_a != lcd_seg_pkg::LEVEL_MID)
      else $error("static backplanes not equal two-level");

   dyn_select_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst) state_reg == lcd_seg_pkg::SELECT_A |->
         backplane_b == lcd_seg_pkg::LEVEL_MID &&
         backplane_a != lcd_seg_pkg::LEVEL_MID)
      else $error("backplane select and mid level disagree");

   all_on_seg_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst)
      all_on |=> segment_outputs == {SEG_N{~common_phase_out}})
      else $error("all-on test did not light every segment");

   blank_seg_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst) blank && !all_on |=> segment_outputs ==
         {SEG_N{common_phase_out}})
      else $error("force-off did not darken every segment");

   sync_quiet_a: assert property (@(posedge osc_clk)
      disable iff (osc_rst) !dyn ##1 !dyn |-> sync_oe_n)
      else $error("sync driven in static mode");

   select_b_c: cover property (@(posedge osc_clk) disable iff (osc_rst)
      state_reg == lcd_seg_pkg::SELECT_B);
   realign_c: cover property (@(posedge osc_clk) disable iff (osc_rst)
      realign);
   handoff_c: cover property (@(posedge osc_clk) disable iff (osc_rst)
      req_s != ack_reg);

endmodule : lcd_seg_driver

// [host_model.sv]
// Host controller model that shifts display bits and pulses the load pin.
// Assumes a free-running clk from the bench; its tasks are called by name.
`timescale 1ns/1ps
module host_model (
   input  wire logic clk,
   output logic      shift_clk,
   output logic      serial_data_in,
   output logic      load_in
);
   // ************************************************************
   // Pin drive
   // ************************************************************
   initial begin
      shift_clk      = 1'b0;
      serial_data_in = 1'b0;
      load_in        = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Data stands four cycles before and six after the rise
   // Same pin order as an upstream chip's chain output
   task automatic shift_bit(input logic d);
      tick(1);
      serial_data_in = d;
      tick(4);
      shift_clk = 1'b1;
      tick(4);
      shift_clk = 1'b0;
      tick(2);
      // Hold time over: show the inverse, never the old value
      serial_data_in = ~d;
   endtask : shift_bit

   task automatic load_pulse();
      tick(1);
      load_in = 1'b1;
      tick(4);
      load_in = 1'b0;
      tick(4);
   endtask : load_pulse
endmodule : host_model

// [testbench.sv]
// Self-checking bench: host model, driver, sync line pull-up.
// Assumes package, synchroniser, driver and host model compiled first.
`timescale 1ns/1ps
module testbench;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [159:0] PAT_A = {40'h0123456789, 40'hABCDEF0F1E,
                                     40'h2D3C4B5A69, 40'h7887966955};
   localparam logic [159:0] PAT_B = {PAT_A[79:0], PAT_A[159:80]};
   logic                              clk;
   logic                              osc_clk;
   logic                              sys_rst;
   logic                              shift_clk;
   logic                              serial_data_in;
   logic                              load_in;
   logic                              display_mode_dynamic;
   logic                              common_source_select;
   logic                              common_clock_in;
   logic                              all_on_test;
   logic                              force_off;
   logic                              sync_in;
   logic                              ext_pull;
   logic                              sync_out;
   logic                              sync_oe_n;
   logic                              half_chain_out;
   logic                              full_chain_out;
   logic                              common_phase_out;
   logic [1:0]                        backplane_a;
   logic [1:0]                        backplane_b;
   logic [lcd_seg_pkg::SEG_COUNT-1:0] segment_outputs;
   logic [159:0]                      exp_chain;
   logic [159:0]                      exp_latch;
   int                                bad_count;
   int                                checks_done;

   // ************************************************************
   // Clocks, line and instances
   // ************************************************************
   initial clk = 1'b0;
   always #25 clk = ~clk;
   initial begin
      osc_clk = 1'b0;
      #7;
      forever #16 osc_clk = ~osc_clk;
   end
   // Pull-up in dynamic mode, grounded in static mode
   // Ext_pull stands for a second chip on the shared line
   assign sync_in = display_mode_dynamic ?
                    (sync_oe_n | sync_out) & ~ext_pull : 1'b0;

   host_model i_host (.clk(clk), .shift_clk(shift_clk),
      .serial_data_in(serial_data_in), .load_in(load_in));

   lcd_seg_driver i_dut (.clk(clk), .sys_rst(sys_rst),
      .shift_clk(shift_clk), .serial_data_in(serial_data_in),
      .load_in(load_in), .display_mode_dynamic(display_mode_dynamic),
      .common_source_select(common_source_select),
      .common_clock_in(common_clock_in), .osc_clk(osc_clk),
      .all_on_test(all_on_test), .force_off(force_off),
      .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
      .half_chain_out(half_chain_out), .full_chain_out(full_chain_out),
      .common_phase_out(common_phase_out), .backplane_a(backplane_a),
      .backplane_b(backplane_b), .segment_outputs(segment_outputs));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input string what, input logic [159:0] seen,
                        input logic [159:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic at_clk();
      @(posedge clk);
      #1;
   endtask : at_clk

   task automatic osc_wait(input int n);
      repeat (n) @(negedge osc_clk);
   endtask : osc_wait

   task automatic send(input logic [159:0] pat);
      for (int i = 159; i >= 0; i--) begin
         i_host.shift_bit(pat[i]);
         exp_chain = {exp_chain[158:0], pat[i]};
         check("half_chain_out", half_chain_out, exp_chain[79]);
         check("full_chain_out", full_chain_out, exp_chain[159]);
      end
   endtask : send

   task automatic load();
      i_host.load_pulse();
      exp_latch = exp_chain;
   endtask : load

   // Segments and backplanes follow the common level sampled with them
   task automatic display(input int n);
      logic [79:0] lit;
      logic [1:0]  lvl;
      logic [3:0]  bp;
      logic        sel_b;
      repeat (n) begin
         @(negedge osc_clk);
         lvl = common_phase_out ? lcd_seg_pkg::LEVEL_HIGH
                                : lcd_seg_pkg::LEVEL_LOW;
         sel_b = display_mode_dynamic &&
                 (backplane_a === lcd_seg_pkg::LEVEL_MID);
         lit = sel_b ? exp_latch[159:80] : exp_latch[79:0];
         if (force_off) lit = '0;
         if (all_on_test) lit = '1;
         bp = sel_b ? {lcd_seg_pkg::LEVEL_MID, lvl} : {lvl, lvl};
         if (display_mode_dynamic && !sel_b) bp[1:0] = lcd_seg_pkg::LEVEL_MID;
         check("backplanes", {backplane_a, backplane_b}, bp);
         check("segments", segment_outputs,
               lit ^ {80{common_phase_out}});
      end
   endtask : display

   task automatic next_rise(inout int lows, output int cnt);
      logic last;
      cnt = 0;
      do begin
         last = common_phase_out;
         @(negedge osc_clk);
         cnt++;
         if (sync_oe_n === 1'b0) lows++;
         if (cnt > 40) begin
            bad_count++;
            report_and_stop();
         end
      end while (!(last === 1'b0 && common_phase_out === 1'b1));
   endtask : next_rise

   task automatic measure(input int per, input int pulses);
      int   cnt;
      int   lows;
      logic sel1;
      lows = 0;
      next_rise(lows, cnt);
      lows = 0;
      next_rise(lows, cnt);
      sel1 = (backplane_a === lcd_seg_pkg::LEVEL_MID);
      check("period_1", cnt, per);
      next_rise(lows, cnt);
      check("period_2", cnt, per);
      check("alternate", sel1 ^ (backplane_a === lcd_seg_pkg::LEVEL_MID),
            display_mode_dynamic);
      check("sync_pulses", lows, pulses);
   endtask : measure

   // Foreign fall lands just after the own guard, before the next rise
   task automatic realign_check();
      int n;
      n = 0;
      while (sync_oe_n !== 1'b0) begin
         @(negedge osc_clk);
         n++;
         if (n > 40) begin
            bad_count++;
            report_and_stop();
         end
      end
      repeat (3) @(posedge osc_clk);
      #1;
      ext_pull = 1'b1;
      osc_wait(4);
      check("realign_common", common_phase_out, 1'b1);
      check("realign_select", {backplane_a, backplane_b},
            {lcd_seg_pkg::LEVEL_HIGH, lcd_seg_pkg::LEVEL_MID});
      check("sync_out", sync_out, 1'b0);
      @(posedge osc_clk);
      #1;
      ext_pull = 1'b0;
   endtask : realign_check

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      sys_rst = 1'b1;
      display_mode_dynamic = 1'b0;
      common_source_select = 1'b0;
      common_clock_in = 1'b0;
      all_on_test = 1'b0;
      force_off = 1'b0;
      ext_pull = 1'b0;
      bad_count = 0;
      checks_done = 0;
      exp_chain = '0;
      exp_latch = '0;
      repeat (11) at_clk();
      check("rst_full", full_chain_out, 1'b0);
      check("rst_segments", segment_outputs, '0);
      check("rst_sync_oe_n", sync_oe_n, 1'b1);
      at_clk();
      sys_rst = 1'b0;
      send(PAT_A);
      load();
      osc_wait(16);
      display(24);
      measure(8, 0);
      // New chain with load low must not reach the segments
      send(PAT_B);
      display(24);
      load();
      osc_wait(16);
      display(24);
      at_clk();
      display_mode_dynamic = 1'b1;
      osc_wait(20);
      measure(4, 1);
      display(32);
      realign_check();
      display(16);
      for (int k = 1; k < 4; k++) begin
         at_clk();
         {all_on_test, force_off} = k[1:0];
         osc_wait(10);
         display(16);
      end
      at_clk();
      {all_on_test, force_off} = 2'h0;
      display_mode_dynamic = 1'b0;
      // Expander, or a slave fed by a master's common
      common_source_select = 1'b1;
      for (int k = 0; k < 2; k++) begin
         at_clk();
         common_clock_in = k[0];
         osc_wait(10);
         check("common_phase_out", common_phase_out, k[0]);
         display(8);
      end
      report_and_stop();
   end
endmodule : testbench
